/* File: bench/bridge_cap_monitor.sv */
/*
 * bridge_cap_monitor: port-level checks on the capability bank read data.
 * assumes: bound to the top module, one clock, reads answered one cycle later.
 */
module bridge_cap_monitor #(
	parameter logic [15:0] CARD_VENDOR_ID = 16'h5a3c, // arbitrary value
	parameter logic [15:0] CARD_ID        = 16'h0c71  // arbitrary value
) (
	input logic        ref_clk_i,
	input logic        rst_i,
	input logic        reverse_strap_i,
	input logic        slot_id_cap_i,
	input logic [7:0]  cfg_addr_i,
	input logic [31:0] cfg_wdata_i,
	input logic        cfg_wr_i,
	input logic        cfg_rd_i,
	input logic [31:0] cfg_rdata_o,
	input logic        reverse_mode_o,
	input logic        settled_o
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);

	// a read taken at one word, and the settle window after reset
	sequence s_rd(logic [7:0] ofs);
		cfg_rd_i && cfg_addr_i == ofs;
	endsequence
	sequence s_settle;
		##[1:6] settled_o;
	endsequence

	// mode bits are judged against the mode seen when the read was taken
	AST_IDLE_ZERO: assert property (!cfg_rd_i |=> cfg_rdata_o == 32'h0)
		else $error("read data not zero outside an answer");
	AST_EXP_LOW: assert property (s_rd(8'hb0) |=> cfg_rdata_o[15:0] == 16'hf010)
		else $error("express header code or link wrong");
	AST_PORT_TYPE: assert property (s_rd(8'hb0) |=>
		cfg_rdata_o[23:20] == ($past(reverse_mode_o) ? 4'h8 : 4'h7))
		else $error("port type does not follow mode");
	AST_SLOT_IMPL: assert property (s_rd(8'hb0) |=>
		cfg_rdata_o[24] == $past(reverse_mode_o))
		else $error("slot implemented bit does not follow mode");
	AST_B0_TOP_ZERO: assert property (s_rd(8'hb0) |=> cfg_rdata_o[31:25] == 7'h00)
		else $error("message number or top bits not zero");
	AST_DEVCAP: assert property (s_rd(8'hb4) |=> cfg_rdata_o[11:0] == 12'h021)
		else $error("device capability fields wrong");
	AST_NEXT_LINK: assert property (s_rd(8'ha8) |=> cfg_rdata_o[31:16] == 16'h0000 &&
		(cfg_rdata_o[15:8] == 8'hb0 || (cfg_rdata_o[15:8] == 8'ha0 && $past(settled_o))))
		else $error("subsystem item link wrong");
	AST_CARD_IDS: assert property (s_rd(8'hac) |=>
		cfg_rdata_o == {CARD_ID, CARD_VENDOR_ID})
		else $error("card identifiers wrong");
	AST_SETTLE: assert property ($fell(rst_i) |-> s_settle)
		else $error("straps not captured in time");
	AST_MODE_HOLD: assert property (settled_o && $past(settled_o) |-> $stable(reverse_mode_o))
		else $error("mode changed after capture");
endmodule

bind bridge_capability_header_regs bridge_cap_monitor #(
	.CARD_VENDOR_ID(CARD_VENDOR_ID),
	.CARD_ID       (CARD_ID)
) i_mon (
	.ref_clk_i      (ref_clk_i),
	.rst_i          (rst_i),
	.reverse_strap_i(reverse_strap_i),
	.slot_id_cap_i  (slot_id_cap_i),
	.cfg_addr_i     (cfg_addr_i),
	.cfg_wdata_i    (cfg_wdata_i),
	.cfg_wr_i       (cfg_wr_i),
	.cfg_rd_i       (cfg_rd_i),
	.cfg_rdata_o    (cfg_rdata_o),
	.reverse_mode_o (reverse_mode_o),
	.settled_o      (settled_o)
);

/* File: bench/bridge_capability_header_regs_bench.sv */
/*
 * bench for the capability bank: all strap settings, every word read against
 * a model, read-only writes, tally saturation, status clear, strap changes.
 * assumes: the checker is bound in from its own file.
 */
module bridge_capability_header_regs_bench;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [15:0] VEN = 16'h1e2f; // arbitrary value
	localparam logic [15:0] CID = 16'h3b4d; // arbitrary value
	localparam logic [7:0]  WORDS [8] = '{8'ha8, 8'hac, 8'hb0, 8'hb4, 8'hc0, 8'hc4, 8'hd0, 8'hae};
	logic        ref_clk_i = 1'b0;
	logic        rst_i     = 1'b1;
	logic        rev       = 1'b0;
	logic        slot      = 1'b0;
	logic        wr        = 1'b0;
	logic        rd        = 1'b0;
	logic [7:0]  addr      = 8'h00;
	logic [31:0] wdata     = 32'h0;
	logic [31:0] rdata;
	logic        rev_o;
	logic        set_o;
	logic        m_rev, m_slot, m_set, ro_seen;
	int          n_mismatch = 0;
	int          compares   = 0;
	int          tally, ctrl, seed, i;

	// 20 mhz clock
	always #25 ref_clk_i = ~ref_clk_i;

	bridge_capability_header_regs #(.CARD_VENDOR_ID(VEN), .CARD_ID(CID)) i_dut (
		.ref_clk_i      (ref_clk_i),
		.rst_i          (rst_i),
		.reverse_strap_i(rev),
		.slot_id_cap_i  (slot),
		.cfg_addr_i     (addr),
		.cfg_wdata_i    (wdata),
		.cfg_wr_i       (wr),
		.cfg_rd_i       (rd),
		.cfg_rdata_o    (rdata),
		.reverse_mode_o (rev_o),
		.settled_o      (set_o)
	);

	task end_sim;
		$display("compares %0d n_mismatch %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask

	// strobes are held for exactly one cycle, then dropped on the next edge
	task wr_w(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk_i);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge ref_clk_i);
		wr <= 1'b0;
	endtask

	task rd_w(input logic [7:0] a, input logic [31:0] exp);
		@(posedge ref_clk_i);
		rd <= 1'b1;
		addr <= a;
		@(posedge ref_clk_i);
		rd <= 1'b0;
		#1 chk($sformatf("word %h", a), exp, rdata);
	endtask

	// behavioural model of every word; before capture the straps read forward
	function automatic logic [31:0] model(input logic [7:0] a);
		case (a)
			8'ha8:   return {16'h0000, (m_slot && ctrl[0]) ? 8'ha0 : 8'hb0, 8'h0d};
			8'hac:   return {CID, VEN};
			8'hb0:   return {7'h00, m_rev, m_rev ? 4'h8 : 4'h7, 4'h1, 8'hf0, 8'h10};
			8'hb4:   return 32'h00000021;
			8'hc0:   return ctrl;
			8'hc4:   return {16'h0000, tally[7:0], 4'h0, ro_seen, m_set, m_slot, m_rev};
			default: return 32'h0;
		endcase
	endfunction

	task check_all;
		for (int w = 0; w < 8; w++) begin
			rd_w(WORDS[w], model(WORDS[w]));
		end
	endtask

	// one pass per strap setting, each preceded by a full reset
	initial begin
		seed = $urandom(32'hda55);
		for (int k = 0; k < 4; k++) begin
			@(posedge ref_clk_i);
			rst_i <= 1'b1;
			rev <= k[0];
			slot <= k[1];
			{m_rev, m_slot, m_set, ro_seen} = 4'h0;
			ctrl = 0;
			tally = 0;
			repeat (16) @(posedge ref_clk_i);
			rst_i <= 1'b0;
			rd_w(8'hb0, model(8'hb0));
			// look just after each edge, once the flops have taken their value
			for (i = 0; i < 20 && set_o !== 1'b1; i++) begin
				@(posedge ref_clk_i);
				#1;
			end
			if (set_o !== 1'b1) begin
				n_mismatch++;
				$display("[ERR] settled expected 1 seen %b", set_o);
				end_sim;
			end
			{m_rev, m_slot, m_set} = {k[0], k[1], 1'b1};
			chk("reverse_mode", {31'h0, k[0]}, {31'h0, rev_o});
			check_all;
			wr_w(8'hc0, 32'h1);
			ctrl = 1;
			rd_w(8'ha8, model(8'ha8));
			// 260 writes pass the tally's saturation point; unmapped writes do not count
			for (int n = 0; n < 260; n++) begin
				wr_w(WORDS[n % 4], $urandom);
				tally = (tally < 255) ? tally + 1 : 255;
				ro_seen = 1'b1;
			end
			wr_w(8'hd0, $urandom);
			rev <= ~k[0];
			slot <= ~k[1];
			check_all;
			wr_w(8'hc4, 32'h8);
			tally = 0;
			ro_seen = 1'b0;
			rd_w(8'hc4, model(8'hc4));
			$display("test %0d done", k);
		end
		end_sim;
	end
endmodule

/* File: shared/bridge_cap_pkg.sv */
/*
 * constants for the bridge capability register bank: word offsets, field
 * positions, fixed field values, own control/status layout and phase codes.
 * assumes: an 8-bit byte address on the config port, 32-bit words.
 */
package bridge_cap_pkg;

	// config port geometry
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;

	// word byte offsets
	localparam logic [7:0] OFS_SUBSYS_CAP = 8'ha8;
	localparam logic [7:0] OFS_CARD_IDS   = 8'hac;
	localparam logic [7:0] OFS_EXP_HDR    = 8'hb0;
	localparam logic [7:0] OFS_DEV_CAP    = 8'hb4;
	localparam logic [7:0] OFS_CTRL       = 8'hc0;
	localparam logic [7:0] OFS_STATUS     = 8'hc4;

	// card_identifier item at a8
	localparam logic [7:0] SUBSYS_CAP_CODE = 8'h0d;
	localparam logic [7:0] NEXT_TO_EXPRESS = 8'hb0;
	localparam logic [7:0] NEXT_TO_SLOT_ID = 8'ha0;

	// express capability header at b0
	localparam logic [7:0] EXP_CAP_CODE  = 8'h10;
	localparam logic [7:0] NEXT_TO_VPD   = 8'hf0;
	localparam logic [3:0] CAP_VERSION   = 4'h1;
	localparam logic [4:0] INT_MSG_NUM   = 5'h00;
	localparam int         POS_VERSION   = 16;
	localparam int         POS_PORT_TYPE = 20;
	localparam int         POS_SLOT_IMPL = 24;
	localparam int         POS_INT_MSG   = 25;

	// device/port type codes, all others reserved
	localparam logic [3:0] TYPE_ENDPOINT     = 4'h0;
	localparam logic [3:0] TYPE_LEGACY_EP    = 4'h1;
	localparam logic [3:0] TYPE_ROOT_PORT    = 4'h4;
	localparam logic [3:0] TYPE_SWITCH_UP    = 4'h5;
	localparam logic [3:0] TYPE_SWITCH_DOWN  = 4'h6;
	localparam logic [3:0] TYPE_EXP_TO_PCI   = 4'h7;
	localparam logic [3:0] TYPE_PCI_TO_EXP   = 4'h8;

	// device capability word at b4
	localparam logic [2:0] PAYLOAD_256    = 3'h1;
	localparam logic [1:0] PHANTOM_NONE   = 2'h0;
	localparam logic       TAG_8BIT       = 1'b1;
	localparam logic [2:0] L0S_UNDER_64NS = 3'h0;
	localparam logic [2:0] L1_UNDER_1US   = 3'h0;
	localparam logic [2:0] L1_32_TO_64US  = 3'h6;
	localparam logic [2:0] L1_OVER_64US   = 3'h7;
	localparam int         POS_PHANTOM    = 3;
	localparam int         POS_TAG        = 5;
	localparam int         POS_L0S        = 6;
	localparam int         POS_L1         = 9;

	// own control and status layout
	localparam int CTRL_SLOT_PTR_BIT = 0;
	localparam int STAT_REVERSE_BIT  = 0;
	localparam int STAT_SLOT_CAP_BIT = 1;
	localparam int STAT_RUN_BIT      = 2;
	localparam int STAT_RO_WR_BIT    = 3;
	localparam int STAT_TALLY_POS    = 8;

	// last settle count; the pin synchroniser fills while it counts 0 to 2 before capture
	localparam logic [1:0] SETTLE_LAST = 2'h2;

	typedef enum logic [1:0] {
		ST_HOLD   = 2'b00,
		ST_SETTLE = 2'b01,
		ST_RUN    = 2'b10
	} cfg_phase_e;

endpackage

/* File: src/bridge_capability_header_regs.sv */
/*
 * bridge_capability_header_regs: configuration-side capability words of the
 * reversible bridge: card_identifier item, card identifiers, express capability
 * header and the lower device capability fields, plus a control word that
 * steers the card_identifier next link and a status word showing block state.
 *
 * word map, by byte offset:
 *   a8: item code 0dh in 7:0, next link in 15:8, zero above
 *   ac: card vendor identifier in 15:0, card identifier in 31:16
 *   b0: code 10h, link f0h, version 1h, port type, slot bit, zero on top
 *   b4: payload 001, no phantoms, eight-bit tag, both latency codes 000
 *   c0: bit 0 picks the a0h link, honoured only with the slot-id item
 *   c4: bit 0 reverse, bit 1 slot-id, bit 2 settled, bit 3 discarded write,
 *       15:8 saturating count of discarded writes; writing bit 3 clears both
 *   b4 bits 31:12 read zero: hot-plug and slot power fields are not built
 *   any other address reads zero and ignores writes
 *
 * assumes: one 20 MHz clock, synchronous active-high reset, a config master
 * issuing one-cycle read or write strobes, never both at once, and taking
 * read data in the cycle after the read strobe; the direction strap and the
 * slot-id enable are board pins that are not yet synchronised.
 * the straps must be steady from reset release until settled_o rises;
 * a later change is only seen after the next reset.
 * read data return to zero between answers, so banks may be or-ed together.
 */

// Summary of operation
// - card_identifier next link reads b0h, or a0h when slot-id capability is enabled and control bit 0 is set
// - word ach bits 15:0 hold the read-only card vendor identifier
// - word ach bits 31:16 hold the read-only card identifier
// - express capability code byte at b0h reads 10h
// - express header next link reads f0h, toward the product data item
// - port type reads 7h in forward mode, 8h in reverse mode
// - port type uses the fixed code set; other codes are reserved
// - slot implemented bit reads 0 forward and 1 reverse
// - interrupt message number and bits 31:30 read zero
// - maximum payload field reads 001, meaning 256 bytes
// - phantom function field reads 00, none supported
// - bit 5 reads 1, eight-bit tag supported
// - acceptable l0s latency field reads 000, under 64 ns
// - acceptable l1 latency field sits in bits 11:9
// - l1 latency codes 110 and 111 mean 32-64 us and over 64 us; reads 000
module bridge_capability_header_regs #(
	parameter logic [15:0] CARD_VENDOR_ID = 16'h5a3c, // arbitrary value
	parameter logic [15:0] CARD_ID        = 16'h0c71  // arbitrary value
) (
	input  logic        ref_clk_i,
	input  logic        rst_i,
	input  logic        reverse_strap_i,
	input  logic        slot_id_cap_i,
	input  logic [7:0]  cfg_addr_i,
	input  logic [31:0] cfg_wdata_i,
	input  logic        cfg_wr_i,
	input  logic        cfg_rd_i,
	output logic [31:0] cfg_rdata_o,
	output logic        reverse_mode_o,
	output logic        settled_o
);

	typedef struct packed {
		bridge_cap_pkg::cfg_phase_e phase;
		logic [1:0]                 settle_cnt;
		logic                       reverse;
		logic                       slot_cap;
		logic                       slot_ptr_sel;
		logic                       ro_write_seen;
		logic [31:0]                rdata;
	} regs_s;

	// reset state is a forward bridge until the strap has been captured
	localparam regs_s REGS_RESET = '{
		phase:         bridge_cap_pkg::ST_HOLD,
		settle_cnt:    2'h0,
		reverse:       1'b0,
		slot_cap:      1'b0,
		slot_ptr_sel:  1'b0,
		ro_write_seen: 1'b0,
		rdata:         32'h0000_0000
	};

	// one flag per mapped word, decoded once for the read mux and the control and status writes
	typedef struct packed {
		logic subsys_cap;
		logic card_ids;
		logic exp_hdr;
		logic dev_cap;
		logic ctrl;
		logic status;
	} word_hit_s;

	regs_s       state_ff;
	regs_s       nxt_state;
	logic [1:0]  pins_sync;
	logic [7:0]  ro_tally;
	logic        ro_write_hit;
	logic        status_clear;
	logic        ctrl_write;
	logic [7:0]  subsys_cap_next_link;
	logic [3:0]  port_type;
	logic [3:0]  port_type_raw;
	logic        settle_done;
	word_hit_s   word_hit;
	logic [31:0] word_subsys_cap;
	logic [31:0] word_card_ids;
	logic [31:0] word_exp_hdr;
	logic [31:0] word_dev_cap;
	logic [31:0] word_ctrl;
	logic [31:0] word_status;
	logic [31:0] read_value;

	// compare the word index and require bits 1:0 zero: a misaligned byte address is unmapped
	function automatic logic hits_word(
		input logic [7:0] addr,
		input logic [7:0] ofs
	);
		hits_word = (addr[7:2] == ofs[7:2]) && (addr[1:0] == 2'b00);
	endfunction

	// any of the four capability words, which software may only read
	function automatic logic hits_cap_word(input logic [7:0] addr);
		hits_cap_word = hits_word(addr, bridge_cap_pkg::OFS_SUBSYS_CAP)
			|| hits_word(addr, bridge_cap_pkg::OFS_CARD_IDS)
			|| hits_word(addr, bridge_cap_pkg::OFS_EXP_HDR)
			|| hits_word(addr, bridge_cap_pkg::OFS_DEV_CAP);
	endfunction

	// legal device/port type codes; everything else is reserved
	function automatic logic port_type_legal(input logic [3:0] code);
		case (code)
			bridge_cap_pkg::TYPE_ENDPOINT:    port_type_legal = 1'b1;
			bridge_cap_pkg::TYPE_LEGACY_EP:   port_type_legal = 1'b1;
			bridge_cap_pkg::TYPE_ROOT_PORT:   port_type_legal = 1'b1;
			bridge_cap_pkg::TYPE_SWITCH_UP:   port_type_legal = 1'b1;
			bridge_cap_pkg::TYPE_SWITCH_DOWN: port_type_legal = 1'b1;
			bridge_cap_pkg::TYPE_EXP_TO_PCI:  port_type_legal = 1'b1;
			bridge_cap_pkg::TYPE_PCI_TO_EXP:  port_type_legal = 1'b1;
			default:                          port_type_legal = 1'b0;
		endcase
	endfunction

	// sticky flag update: a set in the clearing cycle wins, so no event is lost
	function automatic logic sticky_next(
		input logic flag,
		input logic set,
		input logic clear
	);
		sticky_next = (flag && !clear) || set;
	endfunction

	// express capability header for a given port type and slot bit
	function automatic logic [31:0] pack_exp_hdr(
		input logic [3:0] type_code,
		input logic       slot_impl
	);
		pack_exp_hdr       = 32'h0000_0000; // upper two bits stay zero
		pack_exp_hdr[7:0]  = bridge_cap_pkg::EXP_CAP_CODE;
		pack_exp_hdr[15:8] = bridge_cap_pkg::NEXT_TO_VPD;
		pack_exp_hdr[bridge_cap_pkg::POS_VERSION +: 4]   = bridge_cap_pkg::CAP_VERSION;
		pack_exp_hdr[bridge_cap_pkg::POS_PORT_TYPE +: 4] = type_code;
		pack_exp_hdr[bridge_cap_pkg::POS_SLOT_IMPL]      = slot_impl;
		pack_exp_hdr[bridge_cap_pkg::POS_INT_MSG +: 5]   = bridge_cap_pkg::INT_MSG_NUM;
	endfunction

	// strap pins come from the board, so they cross two flops first
	level_sync u_pin_sync (
		.ref_clk_i (ref_clk_i),
		.rst_i     (rst_i),
		.pin_i     ({slot_id_cap_i, reverse_strap_i}),
		.level_o   (pins_sync)
	);

	// counts writes that were thrown away on read-only words
	event_tally u_ro_tally (
		.ref_clk_i (ref_clk_i),
		.rst_i     (rst_i),
		.bump_i    (ro_write_hit),
		.clear_i   (status_clear),
		.count_o   (ro_tally)
	);

	// address decode shared by the control and status write strobes and the read mux
	always_comb begin
		word_hit            = '0;
		word_hit.subsys_cap = hits_word(cfg_addr_i, bridge_cap_pkg::OFS_SUBSYS_CAP);
		word_hit.card_ids   = hits_word(cfg_addr_i, bridge_cap_pkg::OFS_CARD_IDS);
		word_hit.exp_hdr    = hits_word(cfg_addr_i, bridge_cap_pkg::OFS_EXP_HDR);
		word_hit.dev_cap    = hits_word(cfg_addr_i, bridge_cap_pkg::OFS_DEV_CAP);
		word_hit.ctrl       = hits_word(cfg_addr_i, bridge_cap_pkg::OFS_CTRL);
		word_hit.status     = hits_word(cfg_addr_i, bridge_cap_pkg::OFS_STATUS);
	end

	// write decode; a write to a capability word changes no field
	assign ro_write_hit = cfg_wr_i && hits_cap_word(cfg_addr_i);
	assign ctrl_write   = cfg_wr_i && word_hit.ctrl;
	assign status_clear = cfg_wr_i
		&& word_hit.status
		&& cfg_wdata_i[bridge_cap_pkg::STAT_RO_WR_BIT];

	// last count of the settle phase: the synchroniser now holds the straps
	assign settle_done = (state_ff.phase == bridge_cap_pkg::ST_SETTLE)
		&& (state_ff.settle_cnt == bridge_cap_pkg::SETTLE_LAST);

	// the a0h link is only offered when the slot-id item really exists
	always_comb begin
		if (state_ff.slot_cap && state_ff.slot_ptr_sel) begin
			subsys_cap_next_link = bridge_cap_pkg::NEXT_TO_SLOT_ID;
		end else begin
			subsys_cap_next_link = bridge_cap_pkg::NEXT_TO_EXPRESS;
		end
	end

	// port type follows the captured direction; only two codes are reachable,
	// and the legality check keeps a reserved code from ever being shown
	always_comb begin
		if (state_ff.reverse) begin
			port_type_raw = bridge_cap_pkg::TYPE_PCI_TO_EXP;
		end else begin
			port_type_raw = bridge_cap_pkg::TYPE_EXP_TO_PCI;
		end
		port_type = port_type_legal(port_type_raw) ? port_type_raw
			: bridge_cap_pkg::TYPE_EXP_TO_PCI;
	end

	// word at a8: item code, next link, reserved upper half
	always_comb begin
		word_subsys_cap        = 32'h0000_0000;
		word_subsys_cap[7:0]   = bridge_cap_pkg::SUBSYS_CAP_CODE;
		word_subsys_cap[15:8]  = subsys_cap_next_link;
	end

	// word at ac: card identifiers are fixed at build time
	always_comb begin
		word_card_ids        = 32'h0000_0000;
		word_card_ids[15:0]  = CARD_VENDOR_ID;
		word_card_ids[31:16] = CARD_ID;
	end

	// word at b0: express capability header, slot bit follows the direction
	assign word_exp_hdr = pack_exp_hdr(port_type, state_ff.reverse);

	// word at b4: lower device capability fields; slot fields above read zero
	always_comb begin
		word_dev_cap      = 32'h0000_0000;
		word_dev_cap[2:0] = bridge_cap_pkg::PAYLOAD_256;
		word_dev_cap[bridge_cap_pkg::POS_PHANTOM +: 2] = bridge_cap_pkg::PHANTOM_NONE;
		word_dev_cap[bridge_cap_pkg::POS_TAG]          = bridge_cap_pkg::TAG_8BIT;
		word_dev_cap[bridge_cap_pkg::POS_L0S +: 3]     = bridge_cap_pkg::L0S_UNDER_64NS;
		// code 000 of the 3-bit field; 110 and 111 name the two long ranges
		word_dev_cap[bridge_cap_pkg::POS_L1 +: 3]      = bridge_cap_pkg::L1_UNDER_1US;
	end

	// own control word: the link select bit reads back as written
	always_comb begin
		word_ctrl = 32'h0000_0000;
		word_ctrl[bridge_cap_pkg::CTRL_SLOT_PTR_BIT] = state_ff.slot_ptr_sel;
	end

	// own status word: captured straps, phase, sticky flag and tally
	always_comb begin
		word_status = 32'h0000_0000;
		word_status[bridge_cap_pkg::STAT_REVERSE_BIT]  = state_ff.reverse;
		word_status[bridge_cap_pkg::STAT_SLOT_CAP_BIT] = state_ff.slot_cap;
		word_status[bridge_cap_pkg::STAT_RUN_BIT] =
			(state_ff.phase == bridge_cap_pkg::ST_RUN);
		word_status[bridge_cap_pkg::STAT_RO_WR_BIT]    = state_ff.ro_write_seen;
		word_status[bridge_cap_pkg::STAT_TALLY_POS +: 8] = ro_tally;
	end

	// read mux; unmapped and misaligned addresses answer zero
	always_comb begin
		read_value = 32'h0000_0000;
		if (word_hit.subsys_cap) begin
			read_value = word_subsys_cap;
		end else if (word_hit.card_ids) begin
			read_value = word_card_ids;
		end else if (word_hit.exp_hdr) begin
			read_value = word_exp_hdr;
		end else if (word_hit.dev_cap) begin
			read_value = word_dev_cap;
		end else if (word_hit.ctrl) begin
			read_value = word_ctrl;
		end else if (word_hit.status) begin
			read_value = word_status;
		end
	end

	// next state: strap capture sequence, control write, sticky flag, read data
	always_comb begin
		nxt_state = state_ff;

		// straps are caught only once the synchroniser holds settled levels;
		// until then the words show the forward defaults
		case (state_ff.phase)
			bridge_cap_pkg::ST_HOLD: begin
				nxt_state.phase      = bridge_cap_pkg::ST_SETTLE;
				nxt_state.settle_cnt = 2'h0;
			end
			bridge_cap_pkg::ST_SETTLE: begin
				if (settle_done) begin
					nxt_state.phase    = bridge_cap_pkg::ST_RUN;
					nxt_state.reverse  = pins_sync[0];
					nxt_state.slot_cap = pins_sync[1];
				end else begin
					nxt_state.settle_cnt = state_ff.settle_cnt + 2'h1;
				end
			end
			bridge_cap_pkg::ST_RUN: begin
				// direction is a strap: later pin changes need a reset
				nxt_state.phase = bridge_cap_pkg::ST_RUN;
			end
			default: begin
				nxt_state.phase = bridge_cap_pkg::ST_HOLD;
			end
		endcase

		// the only field software may steer
		if (ctrl_write) begin
			nxt_state.slot_ptr_sel = cfg_wdata_i[bridge_cap_pkg::CTRL_SLOT_PTR_BIT];
		end

		// a discarded write sets the flag; setting beats a same-cycle clear
		nxt_state.ro_write_seen = sticky_next(state_ff.ro_write_seen, ro_write_hit,
			status_clear);

		// data stand for the one cycle after the read strobe, zero otherwise
		if (cfg_rd_i) begin
			nxt_state.rdata = read_value;
		end else begin
			nxt_state.rdata = 32'h0000_0000;
		end
	end

	// all block state except the synchroniser and the tally in one register
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			state_ff <= REGS_RESET;
		end else begin
			state_ff <= nxt_state;
		end
	end

	assign cfg_rdata_o    = state_ff.rdata;
	assign reverse_mode_o = state_ff.reverse;
	assign settled_o      = (state_ff.phase == bridge_cap_pkg::ST_RUN);

endmodule

/* File: src/event_tally.sv */
/*
 * event_tally: 8-bit saturating count of one-cycle events with a clear.
 * assumes: bump and clear come from logic on the same clock.
 */
module event_tally (
	input  logic       ref_clk_i,
	input  logic       rst_i,
	input  logic       bump_i,
	input  logic       clear_i,
	output logic [7:0] count_o
);

	typedef struct packed {
		logic [7:0] count;
	} tally_s;

	tally_s state_ff;
	tally_s nxt_state;

	// an event in the clearing cycle still counts, so it is never lost
	always_comb begin
		nxt_state = state_ff;
		if (clear_i) begin
			nxt_state.count = {7'h00, bump_i};
		end else if (bump_i && (state_ff.count != 8'hff)) begin
			nxt_state.count = state_ff.count + 8'h01;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			state_ff <= '0;
		end else begin
			state_ff <= nxt_state;
		end
	end

	assign count_o = state_ff.count;

endmodule

/* File: src/level_sync.sv */
/*
 * level_sync: two-flop synchroniser for the two board strap pins.
 * assumes: pins are slow levels; only the second stage is read outside.
 */
module level_sync (
	input  logic       ref_clk_i,
	input  logic       rst_i,
	input  logic [1:0] pin_i,
	output logic [1:0] level_o
);

	typedef struct packed {
		logic [1:0] meta;
		logic [1:0] stable;
	} sync_s;

	sync_s state_ff;
	sync_s nxt_state;

	// first stage feeds only the second stage
	always_comb begin
		nxt_state        = state_ff;
		nxt_state.meta   = pin_i;
		nxt_state.stable = state_ff.meta;
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			state_ff <= '0;
		end else begin
			state_ff <= nxt_state;
		end
	end

	assign level_o = state_ff.stable;

endmodule
